// file: shared/smf_defines.svh
// constants of the serial memory command front end
`ifndef SMF_DEFINES_SVH
`define SMF_DEFINES_SVH

// ----------------------------------------
// array geometry
// ----------------------------------------
`define SMF_ADDR_W 11
`define SMF_MEM_DEPTH 2048
`define SMF_AHI_KEEP 3

// ----------------------------------------
// opcodes
// ----------------------------------------
`define SMF_OP_SET_LATCH 8'h06
`define SMF_OP_CLR_LATCH 8'h04
`define SMF_OP_STAT_RD 8'h05
`define SMF_OP_STAT_WR 8'h01
`define SMF_OP_ARR_RD 8'h03
`define SMF_OP_ARR_WR 8'h02

// ----------------------------------------
// status byte fields
// ----------------------------------------
`define SMF_ST_LATCH 1
`define SMF_ST_BPL 2
`define SMF_ST_BPH 3
`define SMF_ST_PPE 7
`define SMF_ST_RST 8'h00

// ----------------------------------------
// block protect lower bounds
// ----------------------------------------
`define SMF_PROT_QTR 11'h600
`define SMF_PROT_HALF 11'h400

`endif

// file: shared/smf_pkg.sv
// types shared by the serial memory front end
package smf_pkg;

   // ----------------------------------------
   // link command states, one-hot
   // ----------------------------------------
   typedef enum logic [8:0] {
      SMF_OPC  = 9'h001,
      SMF_AHI  = 9'h002,
      SMF_ALO  = 9'h004,
      SMF_ARD  = 9'h008,
      SMF_AWR  = 9'h010,
      SMF_SRD  = 9'h020,
      SMF_SWR  = 9'h040,
      SMF_SKIP = 9'h080,
      SMF_DONE = 9'h100
   } smf_state_t;

   // ----------------------------------------
   // visible status bits
   // ----------------------------------------
   typedef struct packed {
      logic protect_pin_enable;
      logic block_protect_high;
      logic block_protect_low;
      logic write_latch_flag;
   } smf_status_t;

endpackage : smf_pkg

// file: verilog/smf_sync.sv
// two flip-flop level synchroniser with asynchronous preset value
`timescale 1ns/10ps
`default_nettype none

module smf_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic i_clk,
   input wire logic i_arst,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);

   logic [W-1:0] meta_r; // first stage, read only by q_r
   logic [W-1:0] q_r; // second stage, safe to use

   // ----------------------------------------
   // two stages
   // ----------------------------------------
   // the reset is a constant so it is safe while the clock stands still
   always_ff @(posedge i_clk or posedge i_arst) begin
      if (i_arst) begin
         meta_r <= RST;
         q_r <= RST;
      end else begin
         meta_r <= i_d;
         q_r <= meta_r;
      end
   end

   assign o_q = q_r;

endmodule : smf_sync

`default_nettype wire

// file: verilog/smf_mem.sv
// byte array held in flip-flops, one write port and one read port
`include "smf_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module smf_mem #(
   parameter int DEPTH = `SMF_MEM_DEPTH,
   parameter int AW = `SMF_ADDR_W,
   parameter int DW = 8
) (
   input wire logic i_clk,
   input wire logic i_we,
   input wire logic [AW-1:0] i_waddr,
   input wire logic [DW-1:0] i_wdata,
   input wire logic [AW-1:0] i_raddr,
   output logic [DW-1:0] o_rdata
);

   logic [DW-1:0] mem_r [DEPTH]; // storage, no reset: contents persist

   // ----------------------------------------
   // write port
   // ----------------------------------------
   // a byte lands on the same edge that completes it
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem_r[i_waddr] <= i_wdata;
      end
   end

   // read is combinational so the next byte is ready before its first bit
   assign o_rdata = mem_r[i_raddr];

endmodule : smf_mem

`default_nettype wire

// file: verilog/smf_spi_front.sv
// spi slave command front end of a 2 kbyte serial memory
//
// What this block does
// - 2048 bytes, each on an 11-bit address
// - address in two bytes, top five bits dropped
// - first byte after select is the opcode
// - one opcode per select period
// - deselected: input ignored, output released
// - sample on rising, shift out on falling
// - every byte travels msb first
// - clock level at select picks mode 0/3
// - mode 3 starts at first real rising edge
// - unknown opcode: ignore rest, output released
// - 06h sets latch, 04h clears latch
// - 05h reads status, 01h writes status
// - 03h reads array, 02h writes array
// - latch clear after power-up; set first
// - latch flag only set by set opcode
// - latch cleared at deselect after writes
// - clear opcode blocks writes, flag reads 0
// - 8-bit status register configures protection
// - writes finish inside the serial transfer
// - status byte layout, spare bits zero
// - block protect ranges per two bits
// - bursts increment address, wrap 7ffh to 0
// - status write blocked if pin enable and wp low
`include "smf_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module smf_spi_front
   import smf_pkg::*;
#(
   parameter int ADDR_W = `SMF_ADDR_W,
   parameter int DEPTH = `SMF_MEM_DEPTH
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_sck,
   input wire logic i_cs_n,
   input wire logic i_si,
   input wire logic i_wp_n,
   output logic o_so,
   output logic o_so_oe,
   output smf_status_t o_status,
   output logic o_mode3,
   output logic o_selected
);

   // ----------------------------------------
   // reset bridge
   // ----------------------------------------
   logic link_rst_r; // power-on reset handed to the link side
   logic frame_arst; // ends every frame and covers power-on

   // the link clock may stand still, so its logic is reset asynchronously
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         link_rst_r <= 1'b1;
      end else begin
         link_rst_r <= 1'b0;
      end
   end

   assign frame_arst = i_cs_n | link_rst_r;

   // ----------------------------------------
   // mode capture
   // ----------------------------------------
   logic mode3_r; // 1: clock was high at select

   // clock level sampled by the select edge itself
   always_ff @(negedge i_cs_n or posedge link_rst_r) begin
      if (link_rst_r) begin
         mode3_r <= 1'b0;
      end else begin
         mode3_r <= i_sck;
      end
   end

   // ----------------------------------------
   // link side declarations
   // ----------------------------------------
   smf_state_t state_r; // command state
   smf_state_t state_nxt;
   logic [2:0] bitcnt_r; // bit within byte
   logic [6:0] sh_r; // bits received so far
   logic [7:0] rx_byte; // byte incl. current bit
   logic byte_end; // this edge takes bit 0
   logic wr_r; // address phase leads to a write
   logic [`SMF_AHI_KEEP-1:0] ahi_r; // kept high address bits
   logic [ADDR_W-1:0] addr_r; // burst address
   logic [ADDR_W-1:0] rd_addr; // array read address
   logic [7:0] rd_data; // array read data
   logic mem_we; // array write strobe
   logic ld_r; // next falling edge loads tx_r
   logic [7:0] tx_r; // byte to send
   logic [7:0] txsh_r; // outgoing shifter
   logic so_r; // output bit
   logic oe_r; // output drive
   logic [1:0] bp_r; // block protect bits
   logic ppe_r; // protect pin enable
   logic set_tgl_r; // flips on each set opcode
   logic clr_tgl_r; // flips on each clearing opcode
   logic wp_n_s; // write protect pin, synchronised
   logic wel_s; // latch flag seen by the link side
   logic [7:0] stat_byte; // status as read out
   logic st_ok; // status write allowed

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // true when the address lies in the protected block
   function automatic logic prot_hit(input logic [1:0] bp,
                                     input logic [ADDR_W-1:0] a);
      case (bp)
         2'b01: prot_hit = (a >= `SMF_PROT_QTR);
         2'b10: prot_hit = (a >= `SMF_PROT_HALF);
         2'b11: prot_hit = 1'b1;
         default: prot_hit = 1'b0;
      endcase
   endfunction : prot_hit

   // ----------------------------------------
   // crossings into the link domain
   // ----------------------------------------
   logic wel_r; // write enable latch, system side

   // two rising edges of a frame pass before these settle; the first
   // use of either lies far later in the frame
   smf_sync #(
      .W(2),
      .RST(2'b10)
   ) u_link_sync (
      .i_clk(i_sck),
      .i_arst(link_rst_r),
      .i_d({i_wp_n, wel_r}),
      .o_q({wp_n_s, wel_s})
   );

   // ----------------------------------------
   // receive path
   // ----------------------------------------
   assign rx_byte = {sh_r, i_si};
   assign byte_end = (bitcnt_r == 3'h7);

   // bit counter and shifter, cleared by deselect
   always_ff @(posedge i_sck or posedge frame_arst) begin
      if (frame_arst) begin
         bitcnt_r <= 3'h0;
         sh_r <= 7'h00;
      end else begin
         bitcnt_r <= bitcnt_r + 3'h1;
         sh_r <= rx_byte[6:0];
      end
   end

   // ----------------------------------------
   // command decoder
   // ----------------------------------------
   assign st_ok = wel_s && !(ppe_r && !wp_n_s);
   assign mem_we = (state_r == SMF_AWR) && byte_end && wel_s
                   && !prot_hit(bp_r, addr_r);

   always_comb begin
      state_nxt = state_r;
      if (byte_end) begin
         case (state_r)
            SMF_OPC: begin
               case (rx_byte)
                  `SMF_OP_SET_LATCH: state_nxt = SMF_DONE;
                  `SMF_OP_CLR_LATCH: state_nxt = SMF_DONE;
                  `SMF_OP_STAT_RD: state_nxt = SMF_SRD;
                  `SMF_OP_STAT_WR: state_nxt = SMF_SWR;
                  `SMF_OP_ARR_RD: state_nxt = SMF_AHI;
                  `SMF_OP_ARR_WR: state_nxt = SMF_AHI;
                  default: state_nxt = SMF_SKIP;
               endcase
            end
            SMF_AHI: state_nxt = SMF_ALO;
            SMF_ALO: state_nxt = wr_r ? SMF_AWR : SMF_ARD;
            // a blocked or protected byte stops the burst for good
            SMF_AWR: state_nxt = mem_we ? SMF_AWR : SMF_SKIP;
            SMF_ARD: state_nxt = SMF_ARD;
            SMF_SRD: state_nxt = SMF_DONE;
            SMF_SWR: state_nxt = SMF_DONE;
            // done and skip stay put: one opcode per frame
            SMF_SKIP: state_nxt = SMF_SKIP;
            SMF_DONE: state_nxt = SMF_DONE;
            default: state_nxt = SMF_SKIP;
         endcase
      end
   end

   // state register, back to opcode on every deselect
   always_ff @(posedge i_sck or posedge frame_arst) begin
      if (frame_arst) begin
         state_r <= SMF_OPC;
      end else begin
         state_r <= state_nxt;
      end
   end

   // remembers whether the address is for a read or a write
   always_ff @(posedge i_sck or posedge frame_arst) begin
      if (frame_arst) begin
         wr_r <= 1'b0;
      end else if (state_r == SMF_OPC && byte_end) begin
         wr_r <= (rx_byte == `SMF_OP_ARR_WR);
      end
   end

   // ----------------------------------------
   // address counter
   // ----------------------------------------
   // only the low bits of the high byte survive
   always_ff @(posedge i_sck or posedge frame_arst) begin
      if (frame_arst) begin
         ahi_r <= '0;
         addr_r <= '0;
      end else if (byte_end) begin
         if (state_r == SMF_AHI) begin
            ahi_r <= rx_byte[`SMF_AHI_KEEP-1:0];
         end else if (state_r == SMF_ALO) begin
            addr_r <= {ahi_r, rx_byte};
         end else if (mem_we || state_r == SMF_ARD) begin
            addr_r <= addr_r + 11'h001;
         end
      end
   end

   // ----------------------------------------
   // array
   // ----------------------------------------
   // next byte to read: first one from the fresh address, then addr+1
   assign rd_addr = (state_r == SMF_ALO) ? {ahi_r, rx_byte}
                                          : addr_r + 11'h001;

   smf_mem #(
      .DEPTH(DEPTH),
      .AW(ADDR_W),
      .DW(8)
   ) u_mem (
      .i_clk(i_sck),
      .i_we(mem_we),
      .i_waddr(addr_r),
      .i_wdata(rx_byte),
      .i_raddr(rd_addr),
      .o_rdata(rd_data)
   );

   // ----------------------------------------
   // status register
   // ----------------------------------------
   assign stat_byte = {ppe_r, 3'h0, bp_r, wel_s, 1'b0};

   // nonvolatile in spirit: only power-on reset touches these
   always_ff @(posedge i_sck or posedge link_rst_r) begin
      if (link_rst_r) begin
         ppe_r <= 1'(`SMF_ST_RST >> `SMF_ST_PPE);
         bp_r <= 2'h0;
      end else if (state_r == SMF_SWR && byte_end && st_ok) begin
         // the latch bit of the written byte is dropped on purpose
         ppe_r <= rx_byte[`SMF_ST_PPE];
         bp_r <= {rx_byte[`SMF_ST_BPH], rx_byte[`SMF_ST_BPL]};
      end
   end

   // ----------------------------------------
   // latch events toward the system clock
   // ----------------------------------------
   // toggles survive deselect so no event is lost at frame end
   always_ff @(posedge i_sck or posedge link_rst_r) begin
      if (link_rst_r) begin
         set_tgl_r <= 1'b0;
         clr_tgl_r <= 1'b0;
      end else if (state_r == SMF_OPC && byte_end) begin
         if (rx_byte == `SMF_OP_SET_LATCH) begin
            set_tgl_r <= !set_tgl_r;
         end
         if (rx_byte == `SMF_OP_CLR_LATCH || rx_byte == `SMF_OP_STAT_WR
             || rx_byte == `SMF_OP_ARR_WR) begin
            clr_tgl_r <= !clr_tgl_r;
         end
      end
   end

   // ----------------------------------------
   // transmit load, rising edge
   // ----------------------------------------
   always_ff @(posedge i_sck or posedge frame_arst) begin
      if (frame_arst) begin
         ld_r <= 1'b0;
         tx_r <= 8'h00;
      end else if (byte_end && state_r == SMF_OPC
                   && rx_byte == `SMF_OP_STAT_RD) begin
         ld_r <= 1'b1;
         tx_r <= stat_byte;
      end else if (byte_end && ((state_r == SMF_ALO && !wr_r)
                                || state_r == SMF_ARD)) begin
         ld_r <= 1'b1;
         tx_r <= rd_data;
      end else begin
         ld_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // transmit shift, falling edge
   // ----------------------------------------
   // output released while deselected and outside read phases
   always_ff @(negedge i_sck or posedge frame_arst) begin
      if (frame_arst) begin
         so_r <= 1'b0;
         oe_r <= 1'b0;
         txsh_r <= 8'h00;
      end else if (ld_r) begin
         so_r <= tx_r[7];
         txsh_r <= {tx_r[6:0], 1'b0};
         oe_r <= 1'b1;
      end else begin
         so_r <= txsh_r[7];
         txsh_r <= {txsh_r[6:0], 1'b0};
         oe_r <= oe_r && (state_r == SMF_ARD || state_r == SMF_SRD);
      end
   end

   assign o_so = so_r;
   assign o_so_oe = oe_r;

   // ----------------------------------------
   // crossings into the system domain
   // ----------------------------------------
   logic cs_n_s; // select pin, synchronised
   logic set_s; // set toggle, synchronised
   logic clr_s; // clear toggle, synchronised
   logic mode3_s; // mode flag, synchronised
   logic [2:0] st_s; // protect bits, synchronised
   logic cs_n_q; // delayed select for edge
   logic set_q; // delayed set toggle
   logic clr_q; // delayed clear toggle
   logic clr_pend_r; // a clearing opcode ran this frame
   logic cs_rise; // deselect seen
   logic set_ev; // set opcode seen
   logic clr_ev; // clearing opcode seen

   // protect bits change only on the last edge of a status write, so skew is harmless
   smf_sync #(
      .W(7),
      .RST(7'h40)
   ) u_sys_sync (
      .i_clk(i_clk),
      .i_arst(link_rst_r),
      .i_d({i_cs_n, set_tgl_r, clr_tgl_r, mode3_r, ppe_r, bp_r}),
      .o_q({cs_n_s, set_s, clr_s, mode3_s, st_s})
   );

   // edge memories for the synchronised levels
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         cs_n_q <= 1'b1;
         set_q <= 1'b0;
         clr_q <= 1'b0;
      end else begin
         cs_n_q <= cs_n_s;
         set_q <= set_s;
         clr_q <= clr_s;
      end
   end

   assign cs_rise = cs_n_s && !cs_n_q;
   assign set_ev = set_s ^ set_q;
   assign clr_ev = clr_s ^ clr_q;

   // ----------------------------------------
   // write enable latch
   // ----------------------------------------
   // a clearing opcode arms the clear; the deselect fires it
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         clr_pend_r <= 1'b0;
      end else if (cs_rise) begin
         clr_pend_r <= 1'b0;
      end else if (clr_ev) begin
         clr_pend_r <= 1'b1;
      end
   end

   // set wins over a clear landing in the same cycle
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         wel_r <= 1'b0;
      end else if (set_ev) begin
         wel_r <= 1'b1;
      end else if (cs_rise && (clr_pend_r || clr_ev)) begin
         wel_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign o_status = '{protect_pin_enable: st_s[2],
                       block_protect_high: st_s[1],
                       block_protect_low: st_s[0],
                       write_latch_flag: wel_r};
   assign o_mode3 = mode3_s;
   assign o_selected = !cs_n_s;

endmodule : smf_spi_front

`default_nettype wire

// file: sim/smf_spi_front_sva.sv
// port assertions of the spi memory front end
`timescale 1ns/10ps
`default_nettype none

module smf_spi_front_sva
   import smf_pkg::*;
#(
   parameter int ADDR_W = 11,
   parameter int DEPTH = 2048
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_sck,
   input wire logic i_cs_n,
   input wire logic i_si,
   input wire logic i_wp_n,
   input wire logic o_so,
   input wire logic o_so_oe,
   input wire smf_status_t o_status,
   input wire logic o_mode3,
   input wire logic o_selected
);
   // all checks run on the system clock and rest during reset
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   a_reset_quiet: assert property ($rose(i_rstn) |-> o_status == '0 && !o_mode3)
      else $error("state not clear after reset");
   a_oe_only_sel: assert property (o_so_oe |-> !i_cs_n)
      else $error("output driven while deselected");
   a_select_seen: assert property (!i_cs_n [*4] |-> o_selected)
      else $error("select not seen");
   a_deselect_seen: assert property (i_cs_n [*4] |-> !o_selected)
      else $error("deselect not seen");
   a_mode_holds: assert property (o_selected [*4] |-> $stable(o_mode3))
      else $error("mode moved inside a frame");
   a_status_idle: assert property (i_cs_n [*8] |-> $stable(o_status))
      else $error("status moved while idle");
   a_latch_drop: assert property ($fell(o_status.write_latch_flag) |-> $past(i_cs_n))
      else $error("latch cleared inside a frame");
   // a set only comes from a frame that was just running
   a_latch_rise: assert property ($rose(o_status.write_latch_flag) |->
      $past(o_selected) || $past(o_selected, 2) || $past(o_selected, 3))
      else $error("latch set without a frame");
endmodule : smf_spi_front_sva

`default_nettype wire

// file: sim/smf_spi_master.sv
// spi master model driving the memory link
`timescale 1ns/10ps
`default_nettype none

module smf_spi_master (
   output logic o_sck,
   output logic o_cs_n,
   output logic o_si,
   input wire logic i_so,
   input wire logic i_so_oe
);
   logic m3_r; // mode of the open frame
   logic oe_seen; // output enable seen at any sample
   initial begin
      o_sck = 1'b0;
      o_cs_n = 1'b1;
      o_si = 1'b0;
   end
   // clock parks at the mode level, then select
   task open_f(input logic m3);
      m3_r = m3;
      oe_seen = 1'b0;
      o_sck = m3;
      #20;
      o_cs_n = 1'b0;
      #3;
   endtask : open_f
   // one byte msb first, 6 ns link period
   task xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         o_sck = 1'b0;
         o_si = tx[i];
         #3;
         o_sck = 1'b1;
         // a released line shows the inverse of its last value
         rx[i] = i_so_oe ? i_so : ~i_so;
         oe_seen = oe_seen | i_so_oe;
         #3;
      end
   endtask : xfer
   // clock stands still between frames; si toggles to prove it is ignored
   task close_f();
      o_sck = m3_r;
      #3;
      o_cs_n = 1'b1;
      o_si = ~o_si;
      #210;
   endtask : close_f
endmodule : smf_spi_master

`default_nettype wire

// file: sim/testbench.sv
// self-checking bench of the spi memory front end
`include "smf_defines.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module testbench
   import smf_pkg::*;
();
   logic i_clk, i_rstn, i_wp_n, sck, cs_n, si, so, so_oe, mode3, selected;
   smf_status_t status; // flags seen by the core
   int error_cnt = 0;
   int checks = 0;
   logic [7:0] tx [6]; // bytes of the next frame
   logic [7:0] rx [6]; // bytes sampled back

   initial begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end

   smf_spi_front smf_spi_front_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_sck(sck),
      .i_cs_n(cs_n), .i_si(si), .i_wp_n(i_wp_n), .o_so(so), .o_so_oe(so_oe),
      .o_status(status), .o_mode3(mode3), .o_selected(selected));
   smf_spi_master smf_spi_master_inst (.o_sck(sck), .o_cs_n(cs_n), .o_si(si),
      .i_so(so), .i_so_oe(so_oe));

   // ------------------------------
   // helpers
   // ------------------------------
   task close_out();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : close_out
   // three edges low, four idle edges stand for the power-up delay
   task do_reset();
      @(negedge i_clk);
      i_rstn = 1'b0;
      repeat (3) @(negedge i_clk);
      i_rstn = 1'b1;
      repeat (4) @(negedge i_clk);
   endtask : do_reset
   task frame(input logic m3, input int n);
      smf_spi_master_inst.open_f(m3);
      for (int i = 0; i < n; i++) smf_spi_master_inst.xfer(tx[i], rx[i]);
      smf_spi_master_inst.close_f();
   endtask : frame
   task op(input logic [7:0] c);
      tx[0] = c;
      frame(1'b0, 1);
   endtask : op
   task stat(input logic [7:0] c, input logic [7:0] d);
      tx[0] = c;
      tx[1] = d;
      frame(1'b0, 2);
   endtask : stat
   // bounded wait on the latch flag; a hang ends the run
   task wait_flag(input logic e);
      int n;
      n = 0;
      while (status.write_latch_flag !== e && n < 20) begin
         @(posedge i_clk);
         n++;
      end
      `CHK("latch flag", e, status.write_latch_flag)
      if (status.write_latch_flag !== e) close_out();
   endtask : wait_flag
   task set_latch();
      op(`SMF_OP_SET_LATCH);
      wait_flag(1'b1);
   endtask : set_latch

   // ------------------------------
   // scenarios
   // ------------------------------
   task t_power_up();
      `CHK("status", 4'h0, status)
      stat(`SMF_OP_STAT_RD, 8'h00);
      `CHK("status byte", 8'h00, rx[1])
      set_latch();
      do_reset();
      `CHK("status after reset", 4'h0, status)
      $display("t_power_up done");
   endtask : t_power_up
   task t_latch();
      set_latch();
      stat(`SMF_OP_STAT_RD, 8'h00);
      `CHK("status byte", 8'h02, rx[1])
      op(`SMF_OP_CLR_LATCH);
      wait_flag(1'b0);
      stat(`SMF_OP_STAT_RD, 8'h00);
      `CHK("status byte", 8'h00, rx[1])
      $display("t_latch done");
   endtask : t_latch
   // mode 3 write over the top address with junk high bits, mode 0 read
   task t_burst();
      set_latch();
      tx = '{`SMF_OP_ARR_WR, 8'hff, 8'hff, 8'ha5, 8'h3c, 8'h00};
      frame(1'b1, 5);
      `CHK("mode", 1'b1, mode3)
      `CHK("write enable", 1'b0, smf_spi_master_inst.oe_seen)
      wait_flag(1'b0);
      tx = '{`SMF_OP_ARR_RD, 8'h07, 8'hff, 8'h00, 8'h00, 8'h00};
      frame(1'b0, 5);
      `CHK("mode", 1'b0, mode3)
      `CHK("read enable", 1'b1, smf_spi_master_inst.oe_seen)
      `CHK("data 7ff", 8'ha5, rx[3])
      `CHK("data 000", 8'h3c, rx[4])
      $display("t_burst done");
   endtask : t_burst
   task t_protect();
      set_latch();
      tx = '{`SMF_OP_ARR_WR, 8'h05, 8'hff, 8'h11, 8'h22, 8'h00};
      frame(1'b0, 5);
      set_latch();
      stat(`SMF_OP_STAT_WR, 8'h06);
      wait_flag(1'b0);
      `CHK("status", 4'b0010, status)
      set_latch();
      tx = '{`SMF_OP_ARR_WR, 8'h05, 8'hff, 8'h33, 8'h44, 8'h00};
      frame(1'b0, 5);
      tx = '{`SMF_OP_ARR_RD, 8'h05, 8'hff, 8'h00, 8'h00, 8'h00};
      frame(1'b0, 5);
      `CHK("data 5ff", 8'h33, rx[3])
      `CHK("data 600", 8'h22, rx[4])
      set_latch();
      stat(`SMF_OP_STAT_WR, 8'h8c);
      `CHK("status", 4'b1110, status)
      @(negedge i_clk);
      i_wp_n = 1'b0;
      set_latch();
      stat(`SMF_OP_STAT_WR, 8'h00);
      wait_flag(1'b0);
      `CHK("status locked", 4'b1110, status)
      set_latch();
      tx = '{`SMF_OP_ARR_WR, 8'h00, 8'h00, 8'h55, 8'h00, 8'h00};
      frame(1'b0, 4);
      tx[0] = `SMF_OP_ARR_RD;
      frame(1'b0, 4);
      `CHK("data 000", 8'h3c, rx[3])
      @(negedge i_clk);
      i_wp_n = 1'b1;
      set_latch();
      stat(`SMF_OP_STAT_WR, 8'h00);
      `CHK("status", 4'b0000, status)
      $display("t_protect done");
   endtask : t_protect
   // unknown opcode then a status read code in the same frame
   task t_bad_op();
      tx = '{8'hff, `SMF_OP_STAT_RD, 8'h00, 8'h00, 8'h00, 8'h00};
      frame(1'b0, 4);
      `CHK("bad op enable", 1'b0, smf_spi_master_inst.oe_seen)
      $display("t_bad_op done");
   endtask : t_bad_op

   initial begin
      i_rstn = 1'b0;
      i_wp_n = 1'b1;
      do_reset();
      t_power_up();
      t_latch();
      t_burst();
      t_protect();
      t_bad_op();
      close_out();
   end
endmodule : testbench

bind smf_spi_front smf_spi_front_sva #(.ADDR_W(ADDR_W), .DEPTH(DEPTH)) smf_spi_front_sva_inst (
   .i_clk(i_clk), .i_rstn(i_rstn), .i_sck(i_sck), .i_cs_n(i_cs_n), .i_si(i_si),
   .i_wp_n(i_wp_n), .o_so(o_so), .o_so_oe(o_so_oe), .o_status(o_status),
   .o_mode3(o_mode3), .o_selected(o_selected));

`default_nettype wire
